// File: hw/ifd_pkg.sv
package ifd_pkg;

  // prefix and escape bytes
  localparam logic [7:0] OPSZ_PREFIX = 8'h66;
  localparam logic [7:0] ADSZ_PREFIX = 8'h67;
  localparam logic [7:0] ESCAPE_OP   = 8'h0f;

  // addressing byte encodings
  localparam logic [1:0] MOD_NODISP  = 2'h0;
  localparam logic [1:0] MOD_D8      = 2'h1;
  localparam logic [1:0] MOD_DFULL   = 2'h2;
  localparam logic [1:0] MOD_REG     = 2'h3;
  localparam logic [2:0] RM_SIB      = 3'h4;
  localparam logic [2:0] RM_D32      = 3'h5;
  localparam logic [2:0] RM_D16      = 3'h6;
  localparam logic [2:0] BASE_D32    = 3'h5;
  localparam logic [2:0] SEG_WIDE_MAX = 3'h5;
  localparam logic [2:0] GPR_HIGH_FIRST = 3'h4;

  // field positions inside opcode, addressing and sib bytes
  localparam int W_BIT      = 0;
  localparam int D_BIT      = 1;
  localparam int S_BIT      = 1;
  localparam int HI2_MSB    = 7;
  localparam int HI2_LSB    = 6;
  localparam int MID3_MSB   = 5;
  localparam int MID3_LSB   = 3;
  localparam int LO3_MSB    = 2;
  localparam int LO3_LSB    = 0;
  localparam int SEGN_MSB   = 4;
  localparam int SEGN_LSB   = 3;
  localparam int COND_MSB   = 3;
  localparam int COND_LSB   = 0;

  // byte counts
  localparam logic [2:0] BYTES_0  = 3'h0;
  localparam logic [2:0] BYTES_8  = 3'h1;
  localparam logic [2:0] BYTES_16 = 3'h2;
  localparam logic [2:0] BYTES_32 = 3'h4;
  localparam logic [3:0] LEN_ONE  = 4'h1;

  // byte write masks into a 32-bit destination
  localparam logic [3:0] WMASK_LOW8  = 4'h1;
  localparam logic [3:0] WMASK_HIGH8 = 4'h2;
  localparam logic [3:0] WMASK_16    = 4'h3;
  localparam logic [3:0] WMASK_32    = 4'hf;

  // apb register map
  localparam int          APB_AW      = 12;
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_COUNT   = 12'h008;
  localparam logic [11:0] REG_LAST    = 12'h00c;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam int          CTRL_EN_BIT = 0;
  localparam int          CTRL_CLR_BIT = 1;

  typedef enum logic [1:0] {IMM_NONE, IMM_BYTE, IMM_FULL, IMM_WORD} ifd_imm_kind_t;
  typedef enum logic [1:0] {GPR_FULL32, GPR_FULL16, GPR_LOW8, GPR_HIGH8} ifd_gpr_part_t;
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} ifd_opsize_t;

  // format hint supplied with the last opcode byte
  typedef struct packed {
    logic          has_modrm;
    logic          has_w;
    logic          has_d;
    logic          has_s;
    logic          reg_in_op;
    logic          has_cond;
    logic          has_seg_narrow;
    logic          has_seg_wide;
    ifd_imm_kind_t imm_kind;
  } ifd_hint_t;

  typedef struct packed {
    logic          valid;
    logic [2:0]    idx;
    ifd_gpr_part_t part;
    logic [3:0]    wmask;
  } ifd_gpr_sel_t;

  typedef struct packed {
    logic [3:0]   len;
    logic         op16;
    logic         addr16;
    logic         two_byte;
    logic [7:0]   opcode0;
    logic [7:0]   opcode1;
    ifd_hint_t    hint;
    logic         w;
    logic         d;
    logic         s;
    logic [3:0]   cond;
    logic [1:0]   mod;
    logic [2:0]   reg_f;
    logic [2:0]   rm;
    logic         has_sib;
    logic [1:0]   scale;
    logic [2:0]   index;
    logic [2:0]   base;
    logic [2:0]   disp_len;
    logic [31:0]  disp;
    logic [2:0]   imm_len;
    logic [31:0]  imm;
  } ifd_raw_t;

  typedef struct packed {
    ifd_raw_t     raw;
    ifd_opsize_t  opsize;
    logic [31:0]  imm_ext;
    logic [1:0]   segment_select_narrow;
    logic [2:0]   segment_select_wide;
    logic         seg_invalid;
    ifd_gpr_sel_t gpr_op;
    ifd_gpr_sel_t gpr_reg;
    ifd_gpr_sel_t gpr_rm;
  } ifd_dec_t;

endpackage : ifd_pkg

// File: hw/ifd_gpr_map.sv
`timescale 1ns/1ps
// maps one 3-bit general-register code to a register and its byte lanes
module ifd_gpr_map
  import ifd_pkg::*;
(
  // code and context
  input  wire logic         en_i,
  input  wire logic [2:0]   code_i,
  input  wire logic         has_w_i,
  input  wire logic         w_i,
  input  wire logic         op16_i,
  // mapped register
  output ifd_gpr_sel_t      sel_o
);

  // same decode wherever the code sits in the instruction
  always_comb
  begin
    sel_o       = '0;
    sel_o.valid = en_i;
    sel_o.idx   = code_i;
    if (has_w_i && !w_i)
    begin
      // byte registers: low bytes first, then high bytes of the same four
      sel_o.idx = {1'b0, code_i[1:0]};
      if (code_i >= GPR_HIGH_FIRST)
      begin
        sel_o.part  = GPR_HIGH8;
        sel_o.wmask = WMASK_HIGH8;
      end
      else
      begin
        sel_o.part  = GPR_LOW8;
        sel_o.wmask = WMASK_LOW8;
      end
    end
    else if (op16_i)
    begin
      sel_o.part  = GPR_FULL16;
      sel_o.wmask = WMASK_16;
    end
    else
    begin
      sel_o.part  = GPR_FULL32;
      sel_o.wmask = WMASK_32;
    end
  end

endmodule : ifd_gpr_map

// File: hw/ifd_decoder.sv
// Behaviour
// - opcode bytes, then optional modrm, sib, disp, imm
// - byte after opcode is the addressing byte
// - certain addressing encodings pull in a sib byte
// - displacement after modrm or sib, 8/16/32 bits
// - immediate comes last and ends the instruction
// - width bit picks byte or full size
// - direction bit picks data flow direction
// - sign bit sign-extends a byte immediate
// - addressing byte gives mod and r/m fields
// - sib byte gives scale, index and base
// - narrow and wide segment selectors decoded
// - conditional instructions carry 4-bit condition field
// - 66h/67h give 16-bit size, one instruction only
// - prefix order irrelevant, both together allowed
// - narrow writes keep upper destination bits
// - default 32-bit; width 0 means 8-bit
// - register code decoded alike in every position
// - no width bit: eight full-size registers
// - width 0: low then high bytes
// - 32-bit addressing, r/m 100, mod not 11: sib
// - wide segment codes 110/111 flagged invalid
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic [31:0]            prdata_o,
  // instruction bytes from fetch
  input  wire logic              byte_valid_i,
  input  wire logic [7:0]        byte_i,
  input  wire ifd_hint_t         hint_i,
  output logic                   byte_ready_o,
  // decoded instruction
  output logic                   dec_valid_o,
  output ifd_dec_t               dec_o
);

  typedef enum logic [2:0] {ST_OPCODE, ST_OPCODE2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM}
    ifd_state_t;

  ifd_state_t   state_r;
  ifd_state_t   state_nxt;
  ifd_raw_t     cur_r;
  ifd_raw_t     cur_nxt;
  logic [2:0]   cnt_r;
  logic [2:0]   cnt_nxt;
  logic         final_nxt;
  logic         take;
  logic [31:0]  ctrl_r;
  logic [31:0]  count_r;
  logic         dec_valid_r;
  ifd_dec_t     dec_r;
  logic [31:0]  prdata_r;
  logic         addr_hit;
  ifd_gpr_sel_t gpr_op;
  ifd_gpr_sel_t gpr_reg;
  ifd_gpr_sel_t gpr_rm;

  // fetch must hold its byte while ready is low, so stalling is safe
  assign byte_ready_o = ctrl_r[CTRL_EN_BIT];
  assign take         = byte_valid_i && byte_ready_o;

  // immediate size from the hint, width bit and operand size
  function automatic logic [2:0] imm_bytes(input ifd_hint_t h, input logic w,
                                           input logic op16);
    logic [2:0] n;
    n = BYTES_0;
    case (h.imm_kind)
      IMM_BYTE: n = BYTES_8;
      IMM_WORD: n = BYTES_16;
      IMM_FULL:
      begin
        if (h.has_w && !w)
          n = BYTES_8;
        else if (op16)
          n = BYTES_16;
        else
          n = BYTES_32;
      end
      default: n = BYTES_0;
    endcase
    return n;
  endfunction : imm_bytes

  // what follows once the opcode is complete
  function automatic ifd_state_t after_opcode(input ifd_hint_t h, input logic [2:0] imm);
    ifd_state_t s;
    s = ST_OPCODE;
    if (h.has_modrm)
      s = ST_MODRM;
    else if (imm != BYTES_0)
      s = ST_IMM;
    return s;
  endfunction : after_opcode

  // displacement or immediate, or end of instruction
  function automatic ifd_state_t after_addr(input logic [2:0] disp, input logic [2:0] imm);
    ifd_state_t s;
    s = ST_OPCODE;
    if (disp != BYTES_0)
      s = ST_DISP;
    else if (imm != BYTES_0)
      s = ST_IMM;
    return s;
  endfunction : after_addr

  // byte-serial walk through the instruction format
  always_comb
  begin
    logic [7:0] b;
    b         = byte_i;
    cur_nxt   = cur_r;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    final_nxt = 1'b0;
    if (take)
    begin
      cur_nxt.len = cur_r.len + LEN_ONE;
      case (state_r)
        ST_OPCODE:
        begin
          if (b == OPSZ_PREFIX)
            cur_nxt.op16 = 1'b1;
          else if (b == ADSZ_PREFIX)
            cur_nxt.addr16 = 1'b1;
          else if (b == ESCAPE_OP)
          begin
            cur_nxt.two_byte = 1'b1;
            cur_nxt.opcode0  = b;
            state_nxt        = ST_OPCODE2;
          end
          else
          begin
            cur_nxt.opcode0 = b;
          end
        end
        ST_OPCODE2: cur_nxt.opcode1 = b;
        ST_MODRM:
        begin
          cur_nxt.mod   = b[HI2_MSB:HI2_LSB];
          cur_nxt.reg_f = b[MID3_MSB:MID3_LSB];
          cur_nxt.rm    = b[LO3_MSB:LO3_LSB];
          cur_nxt.has_sib = !cur_r.addr16 && (cur_nxt.rm == RM_SIB)
                            && (cur_nxt.mod != MOD_REG);
          case (cur_nxt.mod)
            MOD_D8:    cur_nxt.disp_len = BYTES_8;
            MOD_DFULL: cur_nxt.disp_len = cur_r.addr16 ? BYTES_16 : BYTES_32;
            MOD_NODISP:
            begin
              if (cur_r.addr16)
                cur_nxt.disp_len = (cur_nxt.rm == RM_D16) ? BYTES_16 : BYTES_0;
              else
                cur_nxt.disp_len = (cur_nxt.rm == RM_D32) ? BYTES_32 : BYTES_0;
            end
            default:   cur_nxt.disp_len = BYTES_0;
          endcase
          if (cur_nxt.has_sib)
            state_nxt = ST_SIB;
          else
            state_nxt = after_addr(cur_nxt.disp_len, cur_r.imm_len);
        end
        ST_SIB:
        begin
          cur_nxt.scale = b[HI2_MSB:HI2_LSB];
          cur_nxt.index = b[MID3_MSB:MID3_LSB];
          cur_nxt.base  = b[LO3_MSB:LO3_LSB];
          // no base register with mod 00 means a 32-bit displacement
          if (cur_r.mod == MOD_NODISP && cur_nxt.base == BASE_D32)
            cur_nxt.disp_len = BYTES_32;
          state_nxt = after_addr(cur_nxt.disp_len, cur_r.imm_len);
        end
        ST_DISP:
        begin
          cur_nxt.disp[cnt_r*8 +: 8] = b;
          cnt_nxt = cnt_r + BYTES_8;
          if (cnt_nxt == cur_r.disp_len)
          begin
            cnt_nxt   = BYTES_0;
            state_nxt = after_addr(BYTES_0, cur_r.imm_len);
          end
        end
        ST_IMM:
        begin
          cur_nxt.imm[cnt_r*8 +: 8] = b;
          cnt_nxt = cnt_r + BYTES_8;
          if (cnt_nxt == cur_r.imm_len)
          begin
            cnt_nxt   = BYTES_0;
            state_nxt = ST_OPCODE;
          end
        end
        default: state_nxt = ST_OPCODE;
      endcase
      // last opcode byte: take the format hint and opcode fields
      if ((state_r == ST_OPCODE && b != OPSZ_PREFIX && b != ADSZ_PREFIX && b != ESCAPE_OP)
          || state_r == ST_OPCODE2)
      begin
        cur_nxt.hint    = hint_i;
        cur_nxt.w       = hint_i.has_w ? b[W_BIT] : 1'b1;
        cur_nxt.d       = hint_i.has_d & b[D_BIT];
        cur_nxt.s       = hint_i.has_s & b[S_BIT];
        cur_nxt.cond    = hint_i.has_cond ? b[COND_MSB:COND_LSB] : 4'h0;
        cur_nxt.imm_len = imm_bytes(hint_i, cur_nxt.w, cur_r.op16);
        state_nxt       = after_opcode(hint_i, cur_nxt.imm_len);
      end
      final_nxt = (state_nxt == ST_OPCODE)
                  && !(state_r == ST_OPCODE && (b == OPSZ_PREFIX || b == ADSZ_PREFIX));
    end
  end

  // fsm and byte counter
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_OPCODE;
      cnt_r   <= BYTES_0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // working copy; prefixes die with the instruction they precede
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cur_r <= '0;
    else if (final_nxt)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  // register-specifier maps, one decoder used in every position
  ifd_gpr_map u_gpr_op (
    .en_i    (cur_nxt.hint.reg_in_op),
    .code_i  (cur_nxt.opcode1[LO3_MSB:LO3_LSB] | (cur_nxt.two_byte ? 3'h0
              : cur_nxt.opcode0[LO3_MSB:LO3_LSB])),
    .has_w_i (cur_nxt.hint.has_w),
    .w_i     (cur_nxt.w),
    .op16_i  (cur_nxt.op16),
    .sel_o   (gpr_op)
  );

  ifd_gpr_map u_gpr_reg (
    .en_i    (cur_nxt.hint.has_modrm && !cur_nxt.hint.has_seg_wide),
    .code_i  (cur_nxt.reg_f),
    .has_w_i (cur_nxt.hint.has_w),
    .w_i     (cur_nxt.w),
    .op16_i  (cur_nxt.op16),
    .sel_o   (gpr_reg)
  );

  ifd_gpr_map u_gpr_rm (
    .en_i    (cur_nxt.hint.has_modrm && cur_nxt.mod == MOD_REG),
    .code_i  (cur_nxt.rm),
    .has_w_i (cur_nxt.hint.has_w),
    .w_i     (cur_nxt.w),
    .op16_i  (cur_nxt.op16),
    .sel_o   (gpr_rm)
  );

  // decoded result, loaded on the last byte and shown the next cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dec_valid_r <= 1'b0;
      dec_r       <= '0;
    end
    else
    begin
      dec_valid_r <= final_nxt;
      if (final_nxt)
      begin
        dec_r.raw     <= cur_nxt;
        dec_r.gpr_op  <= gpr_op;
        dec_r.gpr_reg <= gpr_reg;
        dec_r.gpr_rm  <= gpr_rm;
        if (cur_nxt.hint.has_w && !cur_nxt.w)
          dec_r.opsize <= SZ_8;
        else if (cur_nxt.op16)
          dec_r.opsize <= SZ_16;
        else
          dec_r.opsize <= SZ_32;
        if (cur_nxt.imm_len == BYTES_8 && cur_nxt.s)
          dec_r.imm_ext <= cur_nxt.op16 ? {16'h0000, {8{cur_nxt.imm[7]}}, cur_nxt.imm[7:0]}
                                        : {{24{cur_nxt.imm[7]}}, cur_nxt.imm[7:0]};
        else
          dec_r.imm_ext <= cur_nxt.imm;
        dec_r.segment_select_narrow <= cur_nxt.hint.has_seg_narrow
                                       ? cur_nxt.opcode0[SEGN_MSB:SEGN_LSB] : 2'h0;
        dec_r.segment_select_wide   <= cur_nxt.hint.has_seg_wide ? cur_nxt.reg_f : 3'h0;
        dec_r.seg_invalid <= cur_nxt.hint.has_seg_wide
                             && (cur_nxt.reg_f > SEG_WIDE_MAX);
      end
    end
  end

  assign dec_valid_o = dec_valid_r;
  assign dec_o       = dec_r;

  // control register; clearing the count loses no decode in that cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_r <= CTRL_RESET;
    else if (psel_i && penable_i && pwrite_i && paddr_i == REG_CTRL)
      ctrl_r <= {30'h0, 1'b0, pwdata_i[CTRL_EN_BIT]};
  end

  // decoded-instruction count; a clear in the same cycle as a decode event leaves the count at 1
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      count_r <= 32'h0;
    else if (dec_valid_r)
      count_r <= (psel_i && penable_i && pwrite_i && paddr_i == REG_CTRL
                  && pwdata_i[CTRL_CLR_BIT]) ? 32'h1 : count_r + 32'h1;
    else if (psel_i && penable_i && pwrite_i && paddr_i == REG_CTRL
             && pwdata_i[CTRL_CLR_BIT])
      count_r <= 32'h0;
  end

  // read data captured in the setup cycle, held through access
  assign addr_hit = (paddr_i == REG_CTRL) || (paddr_i == REG_STATUS)
                    || (paddr_i == REG_COUNT) || (paddr_i == REG_LAST);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      prdata_r <= 32'h0;
    else if (psel_i && !penable_i)
    begin
      case (paddr_i)
        REG_CTRL:   prdata_r <= ctrl_r;
        REG_STATUS: prdata_r <= {24'h0, cnt_r, state_r, (state_r != ST_OPCODE),
                                 (cur_r.len != 4'h0)};
        REG_COUNT:  prdata_r <= count_r;
        REG_LAST:   prdata_r <= {22'h0, dec_r.seg_invalid, dec_r.raw.addr16,
                                 dec_r.raw.op16, dec_r.raw.two_byte, dec_r.opsize,
                                 dec_r.raw.len};
        default:    prdata_r <= 32'h0;
      endcase
    end
  end

  // one-cycle access phase, unmapped addresses answer with an error
  assign pready_o  = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !addr_hit;
  assign prdata_o  = prdata_r;

endmodule : ifd_decoder

// File: sim/ifd_decoder_monitor.sv
`timescale 1ns/1ps
// watches decoded output against the byte handshake and the field encodings
module ifd_decoder_monitor
  import ifd_pkg::*;
(
  // clock and reset
  input wire logic     clk_i,
  input wire logic     rst_i,
  // watched ports
  input wire logic     byte_valid_i,
  input wire logic     byte_ready_o,
  input wire logic     dec_valid_o,
  input wire ifd_dec_t dec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a decode with an addressing byte, and one whose opcode has a width bit
  sequence s_modrm;
    dec_valid_o && dec_o.raw.hint.has_modrm;
  endsequence
  sequence s_wbit;
    dec_valid_o && dec_o.raw.hint.has_w;
  endsequence

  a_out_needs_take: assert property (!(byte_valid_i && byte_ready_o) |=> !dec_valid_o)
    else $error("decode pulse without a byte taken");
  a_fields_held: assert property (!dec_valid_o |-> $stable(dec_o))
    else $error("decoded fields moved between pulses");
  a_byte_size: assert property (s_wbit ##0 !dec_o.raw.w |-> dec_o.opsize == SZ_8)
    else $error("width bit 0 not byte size");
  a_full_size: assert property (s_wbit ##0 dec_o.raw.w
    |-> dec_o.opsize == (dec_o.raw.op16 ? SZ_16 : SZ_32)) else $error("full size wrong");
  a_sib_when: assert property (s_modrm |-> dec_o.raw.has_sib == (!dec_o.raw.addr16
    && dec_o.raw.mod != MOD_REG && dec_o.raw.rm == RM_SIB)) else $error("sib presence wrong");
  a_disp8_len: assert property (s_modrm ##0 dec_o.raw.mod == MOD_D8
    |-> dec_o.raw.disp_len == BYTES_8) else $error("mod 01 needs one displacement byte");
  a_byte_regs: assert property (s_wbit ##0 (dec_o.raw.hint.has_modrm
    && dec_o.raw.mod == MOD_REG && !dec_o.raw.w) |-> dec_o.gpr_rm.idx == {1'b0, dec_o.raw.rm[1:0]}
    && dec_o.gpr_rm.part == (dec_o.raw.rm[2] ? GPR_HIGH8 : GPR_LOW8)) else $error("byte reg map");
  a_lane_mask: assert property (dec_valid_o && dec_o.gpr_rm.valid |-> dec_o.gpr_rm.wmask ==
    (dec_o.gpr_rm.part == GPR_LOW8 ? WMASK_LOW8 : dec_o.gpr_rm.part == GPR_HIGH8 ? WMASK_HIGH8
    : dec_o.gpr_rm.part == GPR_FULL16 ? WMASK_16 : WMASK_32)) else $error("lane mask wrong");
  a_seg_invalid: assert property (dec_valid_o && dec_o.raw.hint.has_seg_wide
    |-> dec_o.seg_invalid == (dec_o.segment_select_wide > SEG_WIDE_MAX))
    else $error("segment code validity wrong");
  a_sign_ext: assert property (dec_valid_o && dec_o.raw.hint.imm_kind == IMM_BYTE
    && dec_o.raw.hint.has_s && dec_o.raw.s && !dec_o.raw.op16
    |-> dec_o.imm_ext == {{24{dec_o.raw.imm[7]}}, dec_o.raw.imm[7:0]}) else $error("sign ext");
  c_decode: cover property (byte_valid_i && byte_ready_o ##1 dec_valid_o);
endmodule : ifd_decoder_monitor

bind ifd_decoder ifd_decoder_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o), .dec_valid_o(dec_valid_o),
  .dec_o(dec_o));

// File: sim/ifd_fetch_model.sv
`timescale 1ns/1ps
// fetch side: hands bytes over in program order, with gaps when slow
module ifd_fetch_model
  import ifd_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // pacing
  input  wire logic  slow_i,
  // byte stream to the decoder
  input  wire logic  byte_ready_i,
  output logic       byte_valid_o,
  output logic [7:0] byte_o,
  output ifd_hint_t  hint_o
);
  logic [7:0] q_byte[$];
  ifd_hint_t  q_hint[$];
  logic       gap_r;

  // queue one instruction; every byte carries its format hint
  task automatic push(input logic [7:0] b[$], input ifd_hint_t h);
    foreach (b[i])
    begin
      q_byte.push_back(b[i]);
      q_hint.push_back(h);
    end
  endtask : push

  // a byte stays on the lines until taken; slow leaves every other slot empty
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      byte_valid_o <= 1'b0;
      byte_o       <= 8'h00;
      hint_o       <= '0;
      gap_r        <= 1'b0;
    end
    else if (!byte_valid_o || byte_ready_i)
    begin
      gap_r <= !gap_r;
      if (q_byte.size() != 0 && (!slow_i || gap_r))
      begin
        byte_valid_o <= 1'b1;
        byte_o       <= q_byte.pop_front();
        hint_o       <= q_hint.pop_front();
      end
      else
      begin
        // released line toggles so a stale byte can never pass for data
        byte_valid_o <= 1'b0;
        byte_o       <= ~byte_o;
      end
    end
  end
endmodule : ifd_fetch_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ifd_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, bvalid, bready, dvalid;
  logic [7:0]  bbyte;
  ifd_hint_t   bhint;
  ifd_dec_t    dout, d, dd;
  int          n_mismatch = 0;
  int          total_checks = 0;

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  ifd_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .byte_valid_i(bvalid), .byte_i(bbyte),
    .hint_i(bhint), .byte_ready_o(bready), .dec_valid_o(dvalid), .dec_o(dout));
  ifd_fetch_model i_fetch (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .byte_ready_i(bready), .byte_valid_o(bvalid), .byte_o(bbyte), .hint_o(bhint));

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      chk(1'b0, "apb timeout");
      results();
    end
  endtask : apb

  // sampled at the falling edge, where the one-cycle pulse is settled
  task automatic wait_dec();
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk_i);
      if (dvalid === 1'b1)
        break;
    end
    d = dout;
    if (n == 60)
    begin
      chk(1'b0, "no decode");
      results();
    end
  endtask : wait_dec

  task automatic run(input logic [7:0] b[$], input logic [9:0] h);
    @(negedge clk_i);
    i_fetch.push(b, ifd_hint_t'(h));
    wait_dec();
  endtask : run

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd === CTRL_RESET, "ctrl reset");
    apb(1'b0, 12'h010, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    apb(1'b1, 12'h010, 32'h0);
    chk(err === 1'b1, "unmapped write");
    $display("done: registers");
    run('{8'h83, 8'hc0, 8'h05}, 10'h341);
    chk(d.raw.len === 4'h3 && d.imm_ext === 32'h5 && d.opsize === SZ_32, "imm8");
    chk(d.gpr_rm === ifd_gpr_sel_t'({1'b1, 3'h0, GPR_FULL32, WMASK_32}), "rm32");
    run('{8'h66, 8'h83, 8'hc0, 8'hfb}, 10'h341);
    chk(d.raw.len === 4'h4 && d.imm_ext === 32'h0000_fffb, "op16 imm");
    chk(d.gpr_rm.part === GPR_FULL16 && d.gpr_rm.wmask === WMASK_16, "rm16");
    run('{8'h83, 8'hc0, 8'hfb}, 10'h341);
    chk(d.raw.op16 === 1'b0 && d.imm_ext === 32'hffff_fffb, "prefix once");
    run('{8'h66, 8'h67, 8'h8b, 8'h46, 8'h10}, 10'h380);
    dd = d;
    run('{8'h67, 8'h66, 8'h8b, 8'h46, 8'h10}, 10'h380);
    chk(d === dd && d.raw.addr16 === 1'b1 && d.raw.op16 === 1'b1, "prefix order");
    chk(d.raw.len === 4'h5 && d.raw.disp === 32'h10 && !d.raw.has_sib, "disp8");
    $display("done: prefixes");
    run('{8'h8b, 8'h44, 8'h8d, 8'h20}, 10'h380);
    chk(d.raw.scale === 2'h2 && d.raw.index === 3'h1 && d.raw.base === 3'h5, "sib");
    chk(d.raw.has_sib === 1'b1 && d.raw.len === 4'h4 && d.raw.disp === 32'h20, "sib d8");
    chk(d.raw.d === 1'b1 && d.raw.mod === MOD_D8 && d.raw.rm === RM_SIB, "modrm");
    slow <= 1'b1;
    run('{8'h8b, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12}, 10'h380);
    chk(d.raw.disp === 32'h1234_5678 && d.raw.disp_len === BYTES_32, "disp32");
    chk(d.raw.len === 4'h6 && d.raw.has_sib === 1'b0, "disp32 len");
    run('{8'h8b, 8'h04, 8'h25, 8'h44, 8'h33, 8'h22, 8'h11}, 10'h380);
    chk(d.raw.has_sib === 1'b1 && d.raw.base === 3'h5 && d.raw.len === 4'h7, "sib32");
    chk(d.raw.disp === 32'h1122_3344 && d.raw.disp_len === BYTES_32, "sib disp");
    run('{8'h67, 8'h8b, 8'h86, 8'h34, 8'h12}, 10'h380);
    chk(d.raw.disp === 32'h1234 && d.raw.disp_len === BYTES_16, "disp16");
    chk(d.raw.addr16 === 1'b1 && d.raw.len === 4'h5, "disp16 len");
    slow <= 1'b0;
    $display("done: addressing");
    run('{8'h88, 8'he3}, 10'h380);
    chk(d.gpr_reg === ifd_gpr_sel_t'({1'b1, 3'h0, GPR_HIGH8, WMASK_HIGH8}), "high");
    chk(d.gpr_rm === ifd_gpr_sel_t'({1'b1, 3'h3, GPR_LOW8, WMASK_LOW8}), "low");
    chk(d.opsize === SZ_8 && d.raw.d === 1'b0, "byte op");
    @(negedge clk_i);
    i_fetch.push('{8'h55}, ifd_hint_t'(10'h020));
    i_fetch.push('{8'h66, 8'h55}, ifd_hint_t'(10'h020));
    wait_dec();
    chk(d.gpr_op === ifd_gpr_sel_t'({1'b1, 3'h5, GPR_FULL32, WMASK_32}), "op reg");
    wait_dec();
    chk(d.gpr_op.part === GPR_FULL16 && d.raw.len === 4'h2, "op reg16");
    run('{8'h0f, 8'h85, 8'h10, 8'h00, 8'h00, 8'h00}, 10'h012);
    chk(d.raw.cond === 4'h5 && d.raw.two_byte === 1'b1 && d.raw.len === 4'h6, "cond");
    run('{8'hc2, 8'h08, 8'h00}, 10'h003);
    chk(d.raw.imm_len === BYTES_16 && d.imm_ext === 32'h8 && d.raw.len === 4'h3, "imm16");
    run('{8'hc6, 8'hc0, 8'h7f}, 10'h302);
    chk(d.raw.imm_len === BYTES_8 && d.imm_ext === 32'h7f && d.opsize === SZ_8, "imm w0");
    for (int c = 0; c < 8; c++)
    begin
      run('{8'h8e, {2'h3, c[2:0], 3'h0}}, 10'h204);
      chk(d.segment_select_wide === c[2:0] && d.seg_invalid === (c > 5), "seg3");
    end
    for (int c = 0; c < 4; c++)
    begin
      run('{{3'h0, c[1:0], 3'h6}}, 10'h008);
      chk(d.segment_select_narrow === c[1:0], "seg2");
    end
    $display("done: fields");
    @(negedge clk_i);
    i_fetch.push('{8'h66}, ifd_hint_t'(10'h020));
    repeat (3) @(negedge clk_i);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd === 32'h1, "mid instruction");
    apb(1'b1, REG_CTRL, 32'h0);
    @(negedge clk_i);
    i_fetch.push('{8'h50}, ifd_hint_t'(10'h020));
    repeat (5) @(negedge clk_i);
    chk(bready === 1'b0 && dvalid === 1'b0 && bvalid === 1'b1, "refused");
    apb(1'b1, REG_CTRL, CTRL_RESET);
    wait_dec();
    chk(d.gpr_op.idx === 3'h0 && d.raw.len === 4'h2, "held byte");
    chk(d.raw.op16 === 1'b1 && d.gpr_op.part === GPR_FULL16, "prefix kept");
    apb(1'b0, REG_LAST, 32'h0);
    chk(rd === 32'h92, "last fields");
    apb(1'b0, REG_COUNT, 32'h0);
    chk(rd === 32'h1c, "count");
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b0, REG_COUNT, 32'h0);
    chk(rd === 32'h0, "count clear");
    $display("done: flow control");
    results();
  end
endmodule : tb_top
